// ### core/sbk_top.sv
/*
  Subbank indirect register access for three serial ports and the dma controller.
  Assumes single-cycle read and write strobes from the core on the core clock.
*/
`timescale 1ns/1ps
`include "sbk_cfg.svh"

module sbk_top
  import sbk_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  rd_en_i,
  input  wire logic                  wr_en_i,
  input  wire sbk_pkg::sbk_addr_t    addr_i,
  input  wire sbk_pkg::sbk_word_t    wdata_i,
  output sbk_pkg::sbk_word_t         rdata_o,
  output logic                       rvalid_o,
  output logic                       hit_o,
  output sbk_pkg::sbk_word_t         dma_prio_o,
  output logic [3*`SBK_SP_DEPTH*16-1:0] sp_regs_o,
  output logic [`SBK_DMA_DEPTH*16-1:0]  dma_regs_o
);
  import sbk_pkg::*;

  // =====================================================================
  // subaddress maps
  function automatic logic [31:0] sp_mask();
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      if (i >= int'(`SBK_SP_CTRL1_SUB) && i <= int'(`SBK_SP_PIN_SUB))
        m[i] = 1'b1;
      if (i >= int'(`SBK_SP_EXT_LO_SUB) && i <= int'(`SBK_SP_EXT_HI_SUB))
        m[i] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic [31:0] dma_mask();
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < `SBK_DMA_CHAN_REGS * `SBK_DMA_CHANS; i++)
      m[i] = 1'b1;
    m[`SBK_DMA_SRC_PAGE_SUB] = 1'b1;
    m[`SBK_DMA_DST_PAGE_SUB] = 1'b1;
    return m;
  endfunction

  localparam logic [31:0] SP_MASK  = sp_mask();
  localparam logic [31:0] DMA_MASK = dma_mask();

  // =====================================================================
  // reset release
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // =====================================================================
  // address decode
  localparam sbk_addr_t SP_PTR  [3] = '{`SBK_SP0_PTR_ADDR, `SBK_SP1_PTR_ADDR, `SBK_SP2_PTR_ADDR};
  localparam sbk_addr_t SP_DATA [3] = '{`SBK_SP0_DATA_ADDR, `SBK_SP1_DATA_ADDR, `SBK_SP2_DATA_ADDR};

  logic      sel_sp_ptr  [3];
  logic      sel_sp_data [3];
  sbk_word_t sp_ptr      [3];
  sbk_word_t sp_rdata    [3];
  logic      sel_prio;
  logic      sel_dptr;
  logic      sel_dauto;
  logic      sel_dplain;
  sbk_word_t dma_ptr;
  sbk_word_t dma_rdata;

  assign sel_prio   = (addr_i == `SBK_DMA_PRIO_ADDR);
  assign sel_dptr   = (addr_i == `SBK_DMA_PTR_ADDR);
  assign sel_dauto  = (addr_i == `SBK_DMA_AUTO_ADDR);
  assign sel_dplain = (addr_i == `SBK_DMA_PLAIN_ADDR);

  // =====================================================================
  // serial-port subbanks
  for (genvar p = 0; p < 3; p++)
  begin : g_sp
    assign sel_sp_ptr[p]  = (addr_i == SP_PTR[p]);
    assign sel_sp_data[p] = (addr_i == SP_DATA[p]);

    sbk_subbank #(
      .DEPTH      (`SBK_SP_DEPTH),
      .VALID_MASK (SP_MASK)
    ) u_sp (
      .clk_i     (clk_sys_i),
      .rst_n_i   (rst_n),
      .ptr_wr_i  (wr_en_i && sel_sp_ptr[p]),
      .data_wr_i (wr_en_i && sel_sp_data[p]),
      .data_rd_i (rd_en_i && sel_sp_data[p]),
      .inc_i     (1'b0),
      .wdata_i   (wdata_i),
      .ptr_o     (sp_ptr[p]),
      .rdata_o   (sp_rdata[p]),
      .regs_o    (sp_regs_o[p*`SBK_SP_DEPTH*16 +: `SBK_SP_DEPTH*16])
    );
  end

  // =====================================================================
  // dma subbank, shared by both data ports
  sbk_subbank #(
    .DEPTH      (`SBK_DMA_DEPTH),
    .VALID_MASK (DMA_MASK)
  ) u_dma (
    .clk_i     (clk_sys_i),
    .rst_n_i   (rst_n),
    .ptr_wr_i  (wr_en_i && sel_dptr),
    .data_wr_i (wr_en_i && (sel_dauto || sel_dplain)),
    .data_rd_i (rd_en_i && (sel_dauto || sel_dplain)),
    .inc_i     (sel_dauto),
    .wdata_i   (wdata_i),
    .ptr_o     (dma_ptr),
    .rdata_o   (dma_rdata),
    .regs_o    (dma_regs_o)
  );

  // =====================================================================
  // direct dma priority register
  sbk_word_t prio_q;

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      prio_q <= `SBK_WORD_RST;
    else if (wr_en_i && sel_prio)
      prio_q <= wdata_i;
  end

  assign dma_prio_o = prio_q;

  // =====================================================================
  // read mux, registered so the answer comes one cycle after the strobe
  sbk_word_t rdata_d;
  logic      hit_d;
  sbk_word_t rdata_q;
  logic      rvalid_q;
  logic      hit_q;

  always_comb
  begin
    rdata_d = `SBK_WORD_RST;
    hit_d   = 1'b1;
    if (sel_sp_ptr[0])
      rdata_d = sp_ptr[0];
    else if (sel_sp_ptr[1])
      rdata_d = sp_ptr[1];
    else if (sel_sp_ptr[2])
      rdata_d = sp_ptr[2];
    else if (sel_sp_data[0])
      rdata_d = sp_rdata[0];
    else if (sel_sp_data[1])
      rdata_d = sp_rdata[1];
    else if (sel_sp_data[2])
      rdata_d = sp_rdata[2];
    else if (sel_prio)
      rdata_d = prio_q;
    else if (sel_dptr)
      rdata_d = dma_ptr;
    else if (sel_dauto || sel_dplain)
      rdata_d = dma_rdata;
    else
      hit_d = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q  <= `SBK_WORD_RST;
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
    end
    else
    begin
      rvalid_q <= rd_en_i;
      hit_q    <= (rd_en_i || wr_en_i) && hit_d;
      if (rd_en_i)
        rdata_q <= rdata_d;
    end
  end

  assign rdata_o  = rdata_q;
  assign rvalid_o = rvalid_q;
  assign hit_o    = hit_q;
endmodule

// ### core/sbk_cfg.svh
/*
  Address map, subaddress map and reset values of the subbank access block.
  Assumes a 16-bit data address space and 16-bit data words from the core.
*/
`ifndef SBK_CFG_SVH
`define SBK_CFG_SVH

// =====================================================================
// direct data-memory addresses
`define SBK_SP2_PTR_ADDR    16'h0034
`define SBK_SP2_DATA_ADDR   16'h0035
`define SBK_SP0_PTR_ADDR    16'h0038
`define SBK_SP0_DATA_ADDR   16'h0039
`define SBK_SP1_PTR_ADDR    16'h0048
`define SBK_SP1_DATA_ADDR   16'h0049
`define SBK_DMA_PRIO_ADDR   16'h0054
`define SBK_DMA_PTR_ADDR    16'h0055
`define SBK_DMA_AUTO_ADDR   16'h0056
`define SBK_DMA_PLAIN_ADDR  16'h0057

// =====================================================================
// serial-port subaddresses
`define SBK_SP_CTRL1_SUB    5'h00
`define SBK_SP_CTRL2_SUB    5'h01
`define SBK_SP_RX_CTRL_SUB  5'h02
`define SBK_SP_TX_CTRL_SUB  5'h04
`define SBK_SP_SRATE_SUB    5'h06
`define SBK_SP_MCH_SUB      5'h08
`define SBK_SP_RX_CE_SUB    5'h0A
`define SBK_SP_TX_CE_SUB    5'h0C
`define SBK_SP_PIN_SUB      5'h0E
`define SBK_SP_EXT_LO_SUB   5'h10
`define SBK_SP_EXT_HI_SUB   5'h1B
`define SBK_SP_DEPTH        28

// =====================================================================
// dma subaddresses
`define SBK_DMA_CHAN_REGS   5
`define SBK_DMA_CHANS       6
`define SBK_DMA_SRC_PAGE_SUB 5'h1E
`define SBK_DMA_DST_PAGE_SUB 5'h1F
`define SBK_DMA_DEPTH       32

// =====================================================================
// reset values
`define SBK_WORD_RST        16'h0000
`define SBK_PTR_RST         16'h0000

`endif

// ### core/sbk_pkg.sv
/*
  Types shared by the subbank access block.
  Assumes the core data word is 16 bits wide.
*/
package sbk_pkg;
  typedef logic [15:0] sbk_word_t;
  typedef logic [15:0] sbk_addr_t;
endpackage

// ### core/sbk_subbank.sv
/*
  One pointer/data subbank: a pointer register and a bank of flip-flop registers.
  Assumes the caller decodes the address and never asserts two strobes at once.
*/
`timescale 1ns/1ps
`include "sbk_cfg.svh"

module sbk_subbank
  import sbk_pkg::*;
#(
  parameter int               DEPTH      = `SBK_SP_DEPTH,
  parameter logic [31:0]      VALID_MASK = 32'hFFFF_FFFF
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ptr_wr_i,
  input  wire logic              data_wr_i,
  input  wire logic              data_rd_i,
  input  wire logic              inc_i,
  input  wire sbk_pkg::sbk_word_t wdata_i,
  output sbk_pkg::sbk_word_t     ptr_o,
  output sbk_pkg::sbk_word_t     rdata_o,
  output logic [DEPTH*16-1:0]    regs_o
);
  import sbk_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);

  // =====================================================================
  // elaboration check
  if (DEPTH < 2 || DEPTH > 32)
  begin : g_bad_depth
    $error("sbk_subbank: DEPTH must lie in 2..32");
  end

  sbk_word_t            ptr_q;
  sbk_word_t            mem_q [DEPTH];
  logic     [IDX_W-1:0] idx;
  logic                 hit;

  // =====================================================================
  // decode
  assign idx = ptr_q[IDX_W-1:0];
  assign hit = (ptr_q < 16'(DEPTH)) && VALID_MASK[idx];

  // =====================================================================
  // pointer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ptr_q <= `SBK_PTR_RST;
    else if (ptr_wr_i)
      ptr_q <= wdata_i;
    else if (inc_i && (data_wr_i || data_rd_i))
      ptr_q <= ptr_q + 16'h0001;
    // other data accesses leave the pointer alone
  end

  // =====================================================================
  // register bank
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= `SBK_WORD_RST;
    end
    else if (data_wr_i && hit)
      mem_q[idx] <= wdata_i;
  end

  assign rdata_o = hit ? mem_q[idx] : `SBK_WORD_RST;
  assign ptr_o   = ptr_q;

  for (genvar g = 0; g < DEPTH; g++)
  begin : g_out
    assign regs_o[g*16 +: 16] = mem_q[g];
  end
endmodule

// ### test/sbk_checker_assertions.sv
/*
  Checker for the subbank access block: bus answers, direct dma register and dma subbank.
  Assumes it is bound into sbk_top and sees only its ports.
*/
`timescale 1ns/1ps
`include "sbk_cfg.svh"
module sbk_checker
  import sbk_pkg::*;
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         rd_en_i,
  input  wire logic                         wr_en_i,
  input  wire sbk_pkg::sbk_addr_t           addr_i,
  input  wire sbk_pkg::sbk_word_t           wdata_i,
  input  wire sbk_pkg::sbk_word_t           rdata_o,
  input  wire logic                         rvalid_o,
  input  wire logic                         hit_o,
  input  wire sbk_pkg::sbk_word_t           dma_prio_o,
  input  wire logic [`SBK_DMA_DEPTH*16-1:0] dma_regs_o
);
  // ===================================================================
  // shadow of the dma pointer, since the pointer is not a port
  logic [15:0] dptr_q;
  wire logic   mapped_w = addr_i inside {16'h0034, 16'h0035, 16'h0038, 16'h0039, 16'h0048,
                                         16'h0049, 16'h0054, 16'h0055, 16'h0056, 16'h0057};
  wire logic [4:0] dslot_w = dptr_q[4:0];
  wire sbk_word_t  dsel_w = (dptr_q < 16'h0020) ? dma_regs_o[dslot_w*16 +: 16] : 16'h0000;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i)
      dptr_q <= 16'h0000;
    else if (wr_en_i && addr_i == 16'h0055)
      dptr_q <= wdata_i;
    else if ((wr_en_i || rd_en_i) && addr_i == 16'h0056)
      dptr_q <= dptr_q + 16'h0001;
  // ===================================================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_read_answer: assert property (rd_en_i |=> rvalid_o)
    else $error("read got no answer");
  a_answer_cause: assert property (rvalid_o |-> $past(rd_en_i))
    else $error("answer without a read");
  a_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  a_hit_mapped: assert property ((rd_en_i || wr_en_i) |=> hit_o == $past(mapped_w))
    else $error("hit does not match the address map");
  a_unmapped_zero: assert property (rd_en_i && !mapped_w |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_prio_direct: assert property (wr_en_i && addr_i == 16'h0054 |=> dma_prio_o == $past(wdata_i))
    else $error("priority register write lost");
  a_dptr_read: assert property (rd_en_i && addr_i == 16'h0055 |=> rdata_o == $past(dptr_q))
    else $error("dma pointer read wrong");
  a_dma_read: assert property (rd_en_i && addr_i[15:1] == 15'h002B |=> rdata_o == $past(dsel_w))
    else $error("dma port read wrong");
  a_dma_write: assert property (wr_en_i && addr_i[15:1] == 15'h002B && dptr_q < 16'h0020
    |=> dma_regs_o[$past(dslot_w)*16 +: 16] == $past(wdata_i)) else $error("dma port write lost");
  c_auto_read: cover property (rd_en_i && addr_i == 16'h0056);
  c_ptr_write: cover property (wr_en_i && addr_i == 16'h0055);
  c_unmapped: cover property (rd_en_i && !mapped_w);
endmodule
bind sbk_top sbk_checker i_chk (.clk_sys_i, .rst_b_i, .rd_en_i, .wr_en_i, .addr_i, .wdata_i,
  .rdata_o, .rvalid_o, .hit_o, .dma_prio_o, .dma_regs_o);

// ### test/sbk_core_model.sv
/*
  Core-side bus model: one strobe per clock, reads note the expected answer.
  Assumes each task is entered just after a rising edge.
*/
`timescale 1ns/1ps
module sbk_core_model
  import sbk_pkg::*;
(
  input  wire logic clk_i,
  output logic      rd_en_o,
  output logic      wr_en_o,
  output sbk_addr_t addr_o,
  output sbk_word_t wdata_o
);
  sbk_word_t exp_q[$];
  initial
  begin
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    addr_o  = 16'h0000;
    wdata_o = 16'h0000;
  end
  // unqualified lines toggle so a stale value never looks valid
  task automatic acc(input logic w, input sbk_addr_t a, input sbk_word_t d);
    #1;
    rd_en_o = !w;
    wr_en_o = w;
    addr_o  = a;
    wdata_o = w ? d : ~wdata_o;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk_i);
  endtask
  task automatic idle();
    #1;
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
    @(posedge clk_i);
  endtask
endmodule

// ### test/subbank_indirect_register_access_tb.sv
/*
  Self-checking bench for the subbank access block.
  Assumes the core model drives the bus; reads are checked by the monitor.
*/
`timescale 1ns/1ps
`include "sbk_cfg.svh"
module subbank_indirect_register_access_tb;
  import sbk_pkg::*;
  logic                            clk_sys_i = 1'b0;
  logic                            rst_b_i = 1'b0;
  logic                            rd_en, wr_en, rvalid, hit, ok;
  sbk_addr_t                       addr;
  sbk_word_t                       wdata, rdata, prio, d, m[32];
  logic [3*`SBK_SP_DEPTH*16-1:0]   sp_regs;
  logic [`SBK_DMA_DEPTH*16-1:0]    dma_regs;
  int                              n_fail = 0, cmp_count = 0, cycles = 0;
  integer                          seed = 32'h1f14;
  sbk_addr_t                       ptr_a[3] = '{16'h0038, 16'h0048, 16'h0034};
  always #25 clk_sys_i = ~clk_sys_i;
  sbk_core_model i_core (.clk_i(clk_sys_i), .rd_en_o(rd_en), .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata));
  sbk_top i_dut (.clk_sys_i, .rst_b_i, .rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata),
    .rdata_o(rdata), .rvalid_o(rvalid), .hit_o(hit), .dma_prio_o(prio), .sp_regs_o(sp_regs),
    .dma_regs_o(dma_regs));
  // ===================================================================
  // compare, report, close
  task automatic check(input sbk_word_t seen, input sbk_word_t exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("TB: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // an answer with no note counts as a mismatch, even when the data is unknown
  always @(negedge clk_sys_i)
    if (rvalid === 1'b1)
    begin
      check(16'(i_core.exp_q.size() > 0), 16'h0001);
      if (i_core.exp_q.size() > 0)
        check(rdata, i_core.exp_q.pop_front());
    end
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // ===================================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check(prio, 16'h0000);
    for (int p = 0; p < 3; p++)
      for (int s = 0; s < 32; s++)
      begin
        d = 16'($random(seed));
        ok = (s < `SBK_SP_DEPTH) && (s != 15);
        i_core.acc(1'b1, ptr_a[p], 16'(s));
        i_core.acc(1'b1, ptr_a[p] + 16'h0001, d);
        i_core.acc(1'b0, ptr_a[p] + 16'h0001, ok ? d : 16'h0000);
        i_core.acc(1'b0, ptr_a[p] + 16'h0001, ok ? d : 16'h0000);
        i_core.acc(1'b0, ptr_a[p], 16'(s));
        i_core.idle();
        if (ok)
          check(sp_regs[(p*`SBK_SP_DEPTH+s)*16 +: 16], d);
      end
    i_core.acc(1'b1, 16'h0055, 16'h0000);
    for (int s = 0; s < 32; s++)
    begin
      m[s] = 16'($random(seed));
      i_core.acc(1'b1, 16'h0056, m[s]);
    end
    // pointer now past the bank: write is dropped but still advances
    i_core.acc(1'b1, 16'h0056, 16'hFFFF);
    i_core.acc(1'b0, 16'h0055, 16'h0021);
    i_core.idle();
    for (int s = 0; s < 32; s++)
      check(dma_regs[s*16 +: 16], m[s]);
    i_core.acc(1'b1, 16'h0055, 16'h001D);
    i_core.acc(1'b0, 16'h0056, m[29]);
    i_core.acc(1'b0, 16'h0057, m[30]);
    i_core.acc(1'b1, 16'h0057, 16'h5A5A);
    i_core.acc(1'b0, 16'h0057, 16'h5A5A);
    i_core.acc(1'b0, 16'h0055, 16'h001E);
    i_core.acc(1'b1, 16'h0054, d);
    i_core.acc(1'b0, 16'h0054, d);
    i_core.acc(1'b0, 16'h0036, 16'h0000);
    i_core.acc(1'b1, 16'h0036, d);
    i_core.acc(1'b0, 16'h0058, 16'h0000);
    i_core.idle();
    i_core.idle();
    check(prio, d);
    check(16'(i_core.exp_q.size()), 16'h0000);
    // mid-run reset clears registers and pointers
    #1;
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check(prio, 16'h0000);
    check(dma_regs[30*16 +: 16], 16'h0000);
    check(sp_regs[0 +: 16], 16'h0000);
    #1;
    rst_b_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    i_core.acc(1'b0, 16'h0055, 16'h0000);
    i_core.acc(1'b0, 16'h0038, 16'h0000);
    i_core.idle();
    check(16'(i_core.exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule
